//--- design/qsg_status_group.v
// Questionable data/signal status register group with filters, sticky events and summary
// Contract
// RL1: Condition bit 2 is one while auto interpolator calibration is disabled.
// RL2: Condition bit 5 is one while auto interpolator calibration is disabled.
// RL3: Event bit 8 sets on any of the four calibration failure kinds.
// RL4: Event bits 8, 10 and 14 set directly, bypassing transition filters.
// RL5: Event bit 10 sets on every out-of-limit result, even repeated ones.
// RL6: No limit condition state is kept; bit 10 is not an edge.
// RL7: Event bit 14 sets whenever a command ignores a parameter.
// RL8: Bit 15 always reads zero.
// RL9: Bits 0,1,3,4,6,7,9,11-13 have no function.
// RL10: Throughput settings are saved on save-state and defaulted on reset or power cycle.
// RL11: Reference, checking, auto cal enable, display, expected frequency are not saved.
// RL12: Controller should use group execute trigger when device trigger is fetch.
// RL13: Two filter bits choose rising, falling, either or no edge for event setting.
// RL14: Event bits stay set until the event register is read or clear status.
// RL15: Enable register selects summary contributors; preset and power-on clear it.
// RL16: Summary is OR of event bits ANDed with enable bits.
// RL17: Unused positions of condition, event and enable read as zero.
`timescale 1ns/100ps
`include "qsg_regs.vh"
module qsg_status_group (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   autocal_off,
  input  wire                   cal_fail_bus,
  input  wire                   cal_fail_panel,
  input  wire                   cal_fail_interp,
  input  wire                   cal_fail_meas,
  input  wire                   limit_fail,
  input  wire                   param_ignored,
  input  wire                   cls,
  input  wire                   preset,
  input  wire                   wr_en,
  input  wire                   rd_en,
  input  wire [`QSG_SEL_W-1:0]  sel,
  input  wire [`QSG_W-1:0]      wr_data,
  output reg  [`QSG_W-1:0]      rd_data,
  output wire                   summary
);


  // Positions that carry a condition and so pass through the transition filters
  localparam [`QSG_W-1:0] COND_MASK = `QSG_COND_MASK;

  // Positions that carry any function at all; everything else reads zero in the condition, event and enable registers
  localparam [`QSG_W-1:0] USED_MASK = `QSG_USED_MASK;

  // Filter registers never hold bit 15, which keeps reads in the signed range
  localparam [`QSG_W-1:0] FILT_MASK = 16'h7fff;

  // Stored register state
  reg  [`QSG_W-1:0] cond_r;
  reg  [`QSG_W-1:0] event_r;
  reg  [`QSG_W-1:0] enable_r;
  reg  [`QSG_W-1:0] ptr_r;
  reg  [`QSG_W-1:0] ntr_r;

  // Next values of the stored state
  reg  [`QSG_W-1:0] event_nxt;
  reg  [`QSG_W-1:0] enable_nxt;
  reg  [`QSG_W-1:0] ptr_nxt;
  reg  [`QSG_W-1:0] ntr_nxt;
  reg  [`QSG_W-1:0] rd_data_nxt;

  // Combinational helpers
  reg  [`QSG_W-1:0] rd_nxt;
  wire [`QSG_W-1:0] cond_nxt;
  wire [`QSG_W-1:0] edge_hit;
  wire [`QSG_W-1:0] direct_hit;
  wire [`QSG_W-1:0] contrib;
  wire              cal_fail;
  wire              event_read;
  wire              event_clear;
  wire              wr_enable;
  wire              wr_ptr;
  wire              wr_ntr;

  // True when an access strobe addresses the given register select code
  function sel_is;
    input                  strobe;
    input [`QSG_SEL_W-1:0] code;
    input [`QSG_SEL_W-1:0] want;
    begin
      sel_is = strobe && (code == want);
    end
  endfunction

  // A single bit placed at one position of an otherwise zero word
  function [`QSG_W-1:0] bit_at;
    input         value;
    input integer pos;
    begin
      bit_at      = {`QSG_W{1'b0}};
      bit_at[pos] = value;
    end
  endfunction

  // Access decode; the event read doubles as the event clear
  assign event_read = sel_is(rd_en, sel, `QSG_SEL_EVENT);
  assign wr_enable  = sel_is(wr_en, sel, `QSG_SEL_ENABLE);
  assign wr_ptr     = sel_is(wr_en, sel, `QSG_SEL_PTR);
  assign wr_ntr     = sel_is(wr_en, sel, `QSG_SEL_NTR);

  // Clear status and the event query both empty the sticky bits
  assign event_clear = event_read || cls; // [RL14]

  // Per bit: condition, transition filter and summary contribution
  genvar gi;
  generate
    for (gi = 0; gi < `QSG_W; gi = gi + 1) begin : g_bit
      // Only the two condition positions follow the auto calibration setting
      assign cond_nxt[gi] = COND_MASK[gi] & autocal_off; // [RL1] [RL2] [RL9]

      // Rising edge passes with its positive filter bit, falling with its negative one
      assign edge_hit[gi] = COND_MASK[gi]
                            & ((cond_nxt[gi] & ~cond_r[gi] & ptr_r[gi])
                            | (~cond_nxt[gi] & cond_r[gi] & ntr_r[gi])); // [RL13]

      // An event counts towards the summary only where it is enabled
      assign contrib[gi] = event_r[gi] & enable_r[gi]; // [RL16]
    end
  endgenerate

  // Any calibration failure source raises the error event
  assign cal_fail = cal_fail_bus | cal_fail_panel | cal_fail_interp | cal_fail_meas; // [RL3]

  // Event inputs set directly; limit failure is a pulse per result, no stored state
  assign direct_hit = bit_at(cal_fail, `QSG_BIT_CAL)
                    | bit_at(limit_fail, `QSG_BIT_LIMIT)
                    | bit_at(param_ignored, `QSG_BIT_WARN); // [RL4] [RL5] [RL6] [RL7]

  // Sticky events, cleared on read or clear status; a new event wins over the clear
  always @* begin
    event_nxt = event_r;
    if (event_clear) begin
      event_nxt = {`QSG_W{1'b0}}; // [RL14]
    end
    event_nxt = (event_nxt | edge_hit | direct_hit) & USED_MASK; // [RL8] [RL17]
  end

  // Enable and filter registers; preset beats a write in the same cycle
  always @* begin
    enable_nxt = enable_r;
    ptr_nxt    = ptr_r;
    ntr_nxt    = ntr_r;
    if (preset) begin
      enable_nxt = `QSG_ENA_RST; // [RL15]
      ptr_nxt    = `QSG_PTR_RST;
      ntr_nxt    = `QSG_NTR_RST;
    end else begin
      if (wr_enable) begin
        enable_nxt = wr_data & USED_MASK; // [RL17]
      end
      if (wr_ptr) begin
        ptr_nxt = wr_data & FILT_MASK; // [RL8]
      end
      if (wr_ntr) begin
        ntr_nxt = wr_data & FILT_MASK; // [RL8]
      end
    end
  end

  // Read multiplexer, unused bits masked to zero except in the filter registers
  always @* begin
    case (sel)
      `QSG_SEL_COND: begin
        rd_nxt = cond_r & USED_MASK; // [RL17]
      end
      `QSG_SEL_EVENT: begin
        rd_nxt = event_r & USED_MASK; // [RL8]
      end
      `QSG_SEL_ENABLE: begin
        rd_nxt = enable_r & USED_MASK; // [RL17]
      end
      `QSG_SEL_PTR: begin
        rd_nxt = ptr_r;
      end
      `QSG_SEL_NTR: begin
        rd_nxt = ntr_r;
      end
      default: begin
        rd_nxt = {`QSG_W{1'b0}};
      end
    endcase
  end

  // Read data is captured on the read strobe and holds until the next one
  always @* begin
    rd_data_nxt = rd_data;
    if (rd_en) begin
      rd_data_nxt = rd_nxt;
    end
  end

  // Register state; nothing here survives a power cycle, so no saved copy exists
  always @(posedge clk) begin
    if (!rst_n) begin
      cond_r   <= {`QSG_W{1'b0}};
      event_r  <= {`QSG_W{1'b0}};
      enable_r <= `QSG_ENA_RST; // [RL15] [RL10] [RL11]
      ptr_r    <= `QSG_PTR_RST;
      ntr_r    <= `QSG_NTR_RST;
      rd_data  <= {`QSG_W{1'b0}};
    end else begin
      cond_r   <= cond_nxt;
      event_r  <= event_nxt;
      enable_r <= enable_nxt;
      ptr_r    <= ptr_nxt;
      ntr_r    <= ntr_nxt;
      rd_data  <= rd_data_nxt;
    end
  end

  // Group summary from enabled events
  assign summary = |contrib; // [RL16]

endmodule // qsg_status_group

//--- design/qsg_regs.vh
// Constants for the questionable status group: bit positions, reset values, command codes
`ifndef QSG_REGS_VH
`define QSG_REGS_VH
`define QSG_W            16
`define QSG_BIT_TIME     2
`define QSG_BIT_FREQ     5
`define QSG_BIT_CAL      8
`define QSG_BIT_LIMIT    10
`define QSG_BIT_WARN     14
`define QSG_BIT_SIGN     15
`define QSG_USED_MASK    16'h4524
`define QSG_COND_MASK    16'h0024
`define QSG_EVENT_MASK   16'h4500
`define QSG_ENA_RST      16'h0000
`define QSG_PTR_RST      16'h7fff
`define QSG_NTR_RST      16'h0000
// Register select codes on the command port
`define QSG_SEL_COND     3'h0
`define QSG_SEL_EVENT    3'h1
`define QSG_SEL_ENABLE   3'h2
`define QSG_SEL_PTR      3'h3
`define QSG_SEL_NTR      3'h4
`define QSG_SEL_W        3
`endif

//--- verification/qsg_chk_properties.sv
// Port assertions for the questionable status group
`timescale 1ns/100ps
module qsg_chk(input wire clk,rst_n,autocal_off,cal_fail_bus,cal_fail_panel,cal_fail_interp,cal_fail_meas,
 limit_fail,param_ignored,cls,preset,wr_en,rd_en,summary,input wire [2:0] sel,input wire [15:0] wr_data,rd_data);
  wire rde=rd_en&&sel==3'h1;
  default clocking @(posedge clk); endclocking default disable iff (!rst_n);
  a_sign_zero: assert property(!rd_data[15]) else $error("sign bit set");
  a_unused_zero: assert property($past(rd_en&&sel<3'h3)|->!(rd_data&~16'h4524)) else $error("unused");
  a_cond_follow: assert property(rd_en&&sel==3'h0&&$past(rst_n)|=>
    rd_data==($past(autocal_off,2)?16'h0024:16'h0)) else $error("condition");
  a_cal_event: assert property(rde&&$past(cal_fail_bus|cal_fail_panel|cal_fail_interp|cal_fail_meas)|=>
    rd_data[8]) else $error("calibration");
  a_limit_event: assert property(rde&&$past(limit_fail)|=>rd_data[10]) else $error("limit");
  a_warn_event: assert property(rde&&$past(param_ignored)|=>rd_data[14]) else $error("warning");
  a_read_clears: assert property(rde&&!limit_fail##1 !limit_fail##1 rde|=>!rd_data[10]) else $error("clear");
  a_sum_hold: assert property($fell(summary)|->$past(rd_en||cls||wr_en||preset)) else $error("summary");
  cover property(summary);
  cover property(rde##1 rd_data[10]);
  cover property(rd_data==16'h0024);
endmodule // qsg_chk
bind qsg_status_group qsg_chk chk(.*);

//--- verification/qsg_host.sv
// Controller model for status register accesses
`timescale 1ns/100ps
module qsg_host(input wire clk,input wire [15:0] rd_data,output reg wr_en=0,rd_en=0,
 output reg [2:0] sel=0,output reg [15:0] wr_data=0);
  reg [15:0] q;
  // Results are requested by plain reads; no fetch trigger is modelled
  // One-cycle strobe; select held, data inverted after it; answer caught after the taking edge
  task acc(input w,input [2:0] s,input [15:0] d);
    @(posedge clk) {wr_en,rd_en,sel,wr_data}<={w,!w,s,d};
    @(posedge clk) {wr_en,rd_en,wr_data}<={2'b0,~d};
    #1 q=rd_data;
  endtask
endmodule // qsg_host

//--- verification/test_questionable_status_group.sv
// Bench for the questionable status group
`timescale 1ns/100ps
module test_questionable_status_group;
  reg clk=0,rst_n=0,autocal_off=0,cls=0,preset=0;
  reg [5:0] ev=0,v;
  wire cal_fail_bus=ev[0],cal_fail_panel=ev[1],cal_fail_interp=ev[2],cal_fail_meas=ev[3];
  wire limit_fail=ev[4],param_ignored=ev[5],wr_en,rd_en,summary;
  wire [2:0] sel;
  wire [15:0] wr_data,rd_data;
  integer n_mismatch=0,total_checks=0,cyc=0,i;
  qsg_host h(.*);
  qsg_status_group dut(.*);
  always #20 clk=~clk;
  // One-cycle event pulses and a hang ceiling
  always @(posedge clk) begin
    if (ev) ev<=6'h0;
    if (++cyc>900) begin n_mismatch++; results; end
  end
  task chk(input [15:0] s,e); total_checks++;
    if (s!==e) begin n_mismatch++; $display("ERROR %0t got %h want %h",$time,s,e); end
  endtask
  task results; $display("%0d of %0d checks failed",n_mismatch,total_checks);
    if (n_mismatch==0&&total_checks>0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function [15:0] ex(input [5:0] a); ex={1'b0,a[5],3'h0,a[4],1'b0,|a[3:0],8'h0}; endfunction
  initial begin
    i=$urandom(32'hdef8);
    repeat(6) @(posedge clk); rst_n<=1;
    for (i=2;i<5;i++) begin h.acc(0,i[2:0],0); chk(h.q,i==3?16'h7fff:16'h0); end
    @(posedge clk) autocal_off<=1;
    h.acc(0,0,0); chk(h.q,16'h0024);
    for (i=0;i<2;i++) begin h.acc(0,1,0); chk(h.q,i?16'h0:16'h0024); end
    $display("reset and condition test done");
    for (i=0;i<20;i++) begin
      v=i<2?6'h10:6'($urandom); @(posedge clk) ev<=v;
      h.acc(0,1,0); chk(h.q,ex(v));
    end
    h.acc(1,2,16'hffff); h.acc(0,2,0); chk(h.q,16'h4524);
    @(posedge clk) ev<=6'h10; repeat(2) @(posedge clk); #1 chk(summary,16'h1);
    @(posedge clk) cls<=1; @(posedge clk) cls<=0; #1 chk(summary,16'h0);
    h.acc(1,4,16'h0024); @(posedge clk) autocal_off<=0;
    h.acc(0,1,0); chk(h.q,16'h0024);
    h.acc(1,3,16'h0); @(posedge clk) preset<=1; @(posedge clk) preset<=0;
    for (i=2;i<5;i++) begin h.acc(0,i[2:0],0); chk(h.q,i==3?16'h7fff:16'h0); end
    $display("event and summary test done");
    results;
  end
endmodule // test_questionable_status_group
